// ---- regulator_supervisor_logic.sv ----
/*
 * Supervisor and sequencer of a step-down controller:
 * code decode, power good and fault flags, enable levels,
 * soft start, current limit, gate drive with dead time.
 * Assumes comparator results arrive asynchronously on pins
 * and a classic Wishbone master reaches the registers.
 */
// Decided for this implementation: the Wishbone register port and the register offsets.
// How it works
// - Low range codes 00101..00000 give 1.80-2.05 V
// - Codes 01111..00110 are disabled, no regulation
// - All-ones select code forces shutdown
// - High range codes 11110..10000 give 2.1-3.5 V
// - Power good rises after 1 ms in window
// - Power good falls after 500 us outside window
// - Power good tracks the 95-105 percent window
// - Power good low while enable is low
// - Fifteen percent over drops fault flag, stops gates
// - Overvoltage latch holds until enable toggles
// - Fault flag released while enable is low
// - Over-temperature flag low below 2 V
// - Below 1.7 V both gates forced low
// - Below 1.2 V for 30 us means shutdown
// - Gates never overlap; high side off when disabled
// - Current over limit with high side on cuts duty
// - Hard limit drops soft start, reruns it
// - Free-run 300 kHz or follow faster enable clock
// - Low side waits for first high-side pulse
// - Each enable threshold needs 30 us qualification
// - Enable low stops switching, resets soft start
`timescale 1ns/10ps
module regulator_supervisor_logic #(
    parameter int PG_RISE_CYC = regulator_supervisor_pkg::PG_RISE_CYC,
    parameter int PG_FALL_CYC = regulator_supervisor_pkg::PG_FALL_CYC,
    parameter int EN_QUAL_CYC = regulator_supervisor_pkg::EN_QUAL_CYC,
    parameter int SW_PERIOD_CYC = regulator_supervisor_pkg::SW_PERIOD_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wbCycI,
    input wire logic wbStbI,
    input wire logic wbWeI,
    input wire logic [3:0] wbAdrI,
    input wire logic [31:0] wbDatI,
    input wire logic [3:0] wbSelI,
    output logic [31:0] wbDatO,
    output logic wbAckO,
    input wire logic [4:0] voltageSelectCode,
    input wire regulator_supervisor_pkg::enable_lvl_s enableLevelInput,
    input wire regulator_supervisor_pkg::sense_cmp_s senseCmp,
    input wire regulator_supervisor_pkg::stage_cmp_s stageCmp,
    output logic highSideGate,
    output logic lowSideGate,
    output logic powerGoodFlag,
    output logic overVoltFlag_n,
    output logic overTempFlag_n,
    output logic [8:0] targetCentivolts
);

    localparam int SYNC_W = 14;
    localparam logic [17:0] PG_RISE_LIM = 18'(PG_RISE_CYC);
    localparam logic [17:0] PG_FALL_LIM = 18'(PG_FALL_CYC);
    localparam logic [17:0] QUAL_LIM = 18'(EN_QUAL_CYC);
    localparam logic [9:0] PERIOD_LAST = 10'(SW_PERIOD_CYC - 1);
    localparam logic [9:0] PERIOD_FULL = 10'(SW_PERIOD_CYC);
    localparam logic [9:0] SS_STEP_LAST = 10'(regulator_supervisor_pkg::SS_STEP_CYC - 1);
    localparam logic [9:0] CL_DUTY_STEP = 10'(regulator_supervisor_pkg::CL_STEP);
    localparam logic [3:0] NOL_LIM = 4'(regulator_supervisor_pkg::NOL_CYC);

    // Two-stage synchronisers
    logic [13:0] syncA_r; // First stage, read only by the second
    logic [13:0] syncB_r; // Second stage, safe to use
    logic [4:0] codeS; // Synchronised select code
    regulator_supervisor_pkg::enable_lvl_s enS; // Synchronised enable levels
    regulator_supervisor_pkg::sense_cmp_s senseS; // Synchronised sense comparators
    regulator_supervisor_pkg::stage_cmp_s stageS; // Synchronised stage comparators
    logic enPrev_r; // Enable above 2 V one cycle ago, for edge detection

    // Enable-level qualification
    logic [17:0] qualCnt_r [3]; // Cycles each threshold has been undercut
    logic [2:0] belowQual; // Qualified: 0 warning, 1 driver disable, 2 shutdown

    // Code decode and mode
    logic codeShutdown; // All-ones select code
    logic codeDisabled; // Code selects no regulated output
    logic shutdownMode; // Whole converter is off
    logic gatesAllowed; // Drivers may switch

    // Flags
    logic [17:0] winCnt_r; // Cycles continuously inside the window
    logic [17:0] outCnt_r; // Cycles continuously outside the window
    logic overVolt_r; // Latched overvoltage state

    // Switching and soft start
    regulator_supervisor_pkg::conv_state_e state_r;
    logic [9:0] phase_r; // Position inside the switching period
    logic [9:0] ssLevel_r; // Soft start duty ceiling, in phase counts
    logic [9:0] ssTick_r; // Divider for soft start ramp steps
    logic pwmDone_r; // PWM comparator tripped this period
    logic firstHigh_r; // High side has switched since soft start began
    logic [3:0] deadCnt_r; // Cycles both gates have been low
    logic hsReq; // High side wanted on
    logic lsReq; // Low side wanted on
    logic bothLow; // Neither gate driven
    logic syncEdge; // Rising edge of an external clock on enable
    logic hsNxt;
    logic lsNxt;

    // Registers and bus
    logic [1:0] ctrl_r; // Driver inhibit and current-limit enable
    logic wbReq; // Valid bus cycle awaiting answer

    // Synchroniser chain
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            syncA_r <= '0;
            syncB_r <= '0;
            enPrev_r <= 1'b0;
        end else begin
            syncA_r <= {voltageSelectCode, enableLevelInput, senseCmp, stageCmp};
            syncB_r <= syncA_r;
            enPrev_r <= enS.above2v;
        end
    end

    assign {codeS, enS, senseS, stageS} = syncB_r;

    // Per-threshold undercut counters, saturating at the qualification time
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                qualCnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (enS[2 - i]) begin
                    qualCnt_r[i] <= '0; // Level back above threshold
                end else if (qualCnt_r[i] != QUAL_LIM) begin
                    qualCnt_r[i] <= qualCnt_r[i] + 18'h00001;
                end
            end
        end
    end

    // A threshold counts only once undercut for the full time
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            belowQual[i] = (qualCnt_r[i] == QUAL_LIM);
        end
    end

    // Select code classes and overall operating permission
    always_comb begin
        codeShutdown = (codeS == regulator_supervisor_pkg::CODE_SHUTDOWN);
        codeDisabled = !codeS[4] && (codeS[3:0] > regulator_supervisor_pkg::LOW_LAST_VALID);
        shutdownMode = belowQual[2] || codeShutdown;
        gatesAllowed = !shutdownMode && !codeDisabled && !belowQual[1]
            && !overVolt_r && !ctrl_r[regulator_supervisor_pkg::CTRL_INHIBIT_BIT];
    end

    // Target voltage decode, zero for disabled and shutdown codes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            targetCentivolts <= '0;
        end else if (codeShutdown || codeDisabled) begin
            targetCentivolts <= '0;
        end else if (codeS[4]) begin
            targetCentivolts <= regulator_supervisor_pkg::HIGH_BASE_CV
                - 9'(codeS[3:0] * regulator_supervisor_pkg::HIGH_STEP_CV);
        end else begin
            targetCentivolts <= regulator_supervisor_pkg::LOW_BASE_CV
                - 9'(codeS[3:0] * regulator_supervisor_pkg::LOW_STEP_CV);
        end
    end

    // Window dwell counters feeding power good
    always_ff @(posedge clk_sys) begin
        if (!rst_n || shutdownMode) begin
            winCnt_r <= '0;
            outCnt_r <= '0;
        end else if (!senseS.below95 && !senseS.above105) begin
            outCnt_r <= '0;
            if (winCnt_r != PG_RISE_LIM) begin
                winCnt_r <= winCnt_r + 18'h00001;
            end
        end else begin
            winCnt_r <= '0;
            if (outCnt_r != PG_FALL_LIM) begin
                outCnt_r <= outCnt_r + 18'h00001;
            end
        end
    end

    // Power good set and clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            powerGoodFlag <= 1'b0;
        end else if (shutdownMode || codeDisabled) begin
            powerGoodFlag <= 1'b0;
        end else if (winCnt_r == PG_RISE_LIM) begin
            powerGoodFlag <= 1'b1;
        end else if (outCnt_r == PG_FALL_LIM) begin
            powerGoodFlag <= 1'b0;
        end
    end

    // Overvoltage latch; a clear in the same cycle as a set wins, as shutdown masks the set
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            overVolt_r <= 1'b0;
        end else if (!shutdownMode && senseS.above115) begin
            overVolt_r <= 1'b1;
        end else if (belowQual[2]) begin
            overVolt_r <= 1'b0;
        end
    end

    // Open-drain style flags: low while asserted, high when released
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            overVoltFlag_n <= 1'b1;
            overTempFlag_n <= 1'b1;
        end else begin
            overVoltFlag_n <= !(overVolt_r && !belowQual[2]);
            overTempFlag_n <= !belowQual[0];
        end
    end

    // Enable rising edge marks an external sync clock
    assign syncEdge = enS.above2v && !enPrev_r;

    // Period counter, restarted by an external clock
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r <= '0;
        end else if (phase_r == PERIOD_LAST || syncEdge) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_r + 10'h001;
        end
    end

    // Sequencer and soft start ceiling
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !gatesAllowed) begin
            state_r <= regulator_supervisor_pkg::ST_OFF;
            ssLevel_r <= '0;
            ssTick_r <= '0;
        end else if (stageS.hardLimit
                && ctrl_r[regulator_supervisor_pkg::CTRL_LIMIT_EN_BIT]) begin
            state_r <= regulator_supervisor_pkg::ST_SOFT;
            ssLevel_r <= '0;
            ssTick_r <= '0;
        end else begin
            unique case (state_r)
                regulator_supervisor_pkg::ST_OFF: begin
                    state_r <= regulator_supervisor_pkg::ST_SOFT;
                end
                regulator_supervisor_pkg::ST_SOFT, regulator_supervisor_pkg::ST_RUN: begin
                    if (highSideGate && stageS.belowLimit
                            && ctrl_r[regulator_supervisor_pkg::CTRL_LIMIT_EN_BIT]) begin
                        // Soft limit: pull the ceiling down
                        ssLevel_r <= (ssLevel_r > CL_DUTY_STEP) ?
                            ssLevel_r - CL_DUTY_STEP : '0;
                        state_r <= regulator_supervisor_pkg::ST_SOFT;
                        ssTick_r <= '0;
                    end else if (ssLevel_r == PERIOD_FULL) begin
                        state_r <= regulator_supervisor_pkg::ST_RUN;
                    end else if (ssTick_r == SS_STEP_LAST) begin
                        ssTick_r <= '0;
                        ssLevel_r <= ssLevel_r + 10'h001;
                    end else begin
                        ssTick_r <= ssTick_r + 10'h001;
                    end
                end
                default: begin
                    state_r <= regulator_supervisor_pkg::ST_OFF;
                end
            endcase
        end
    end

    // PWM trip ends the high-side pulse for the period
    always_ff @(posedge clk_sys) begin
        if (!rst_n || phase_r == PERIOD_LAST || syncEdge) begin
            pwmDone_r <= 1'b0;
        end else if (stageS.pwmTrip) begin
            pwmDone_r <= 1'b1;
        end
    end

    // Gate requests before dead-time shaping
    always_comb begin
        bothLow = !highSideGate && !lowSideGate;
        hsReq = gatesAllowed && state_r != regulator_supervisor_pkg::ST_OFF
            && phase_r < ssLevel_r && !pwmDone_r && !stageS.pwmTrip;
        lsReq = gatesAllowed && !hsReq && firstHigh_r;
        hsNxt = hsReq && (highSideGate || (bothLow && deadCnt_r == NOL_LIM));
        lsNxt = lsReq && (lowSideGate || (bothLow && deadCnt_r == NOL_LIM));
    end

    // Dead-time counter and first-pulse tracking
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            deadCnt_r <= '0;
            firstHigh_r <= 1'b0;
        end else begin
            if (!bothLow) begin
                deadCnt_r <= '0;
            end else if (deadCnt_r != NOL_LIM) begin
                deadCnt_r <= deadCnt_r + 4'h1;
            end
            if (state_r == regulator_supervisor_pkg::ST_OFF || ssLevel_r == '0) begin
                firstHigh_r <= 1'b0;
            end else if (highSideGate) begin
                firstHigh_r <= 1'b1;
            end
        end
    end

    // Gate drive outputs
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            highSideGate <= 1'b0;
            lowSideGate <= 1'b0;
        end else begin
            highSideGate <= hsNxt;
            lowSideGate <= lsNxt;
        end
    end

    // Wishbone slave: one-cycle answer, ack drops in the following cycle
    assign wbReq = wbCycI && wbStbI && !wbAckO;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wbAckO <= 1'b0;
        end else begin
            wbAckO <= wbReq;
        end
    end

    // Control register write, low byte lane only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_r <= regulator_supervisor_pkg::CTRL_RESET;
        end else if (wbReq && wbWeI && wbSelI[0]
                && wbAdrI == regulator_supervisor_pkg::REG_CTRL) begin
            ctrl_r <= wbDatI[1:0];
        end
    end

    // Read data; unmapped addresses read zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wbDatO <= '0;
        end else if (wbReq && !wbWeI) begin
            unique case (wbAdrI)
                regulator_supervisor_pkg::REG_CTRL: wbDatO <= {30'h0, ctrl_r};
                regulator_supervisor_pkg::REG_STATUS: wbDatO <= {16'h0, codeS, state_r,
                    belowQual, overVolt_r, powerGoodFlag, lowSideGate, highSideGate,
                    shutdownMode, codeDisabled};
                regulator_supervisor_pkg::REG_TARGET: wbDatO <= {23'h0, targetCentivolts};
                default: wbDatO <= '0;
            endcase
        end
    end

endmodule

// ---- regulator_supervisor_pkg.sv ----
/*
 * Constants, types and carriers of the regulator supervisor.
 * Assumes one 200 MHz clock; every time here is turned into a cycle count.
 */
package regulator_supervisor_pkg;

    // System clock
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_NS = 5;

    // Free-running switching period
    localparam int SW_FREQ_KHZ = 300;
    localparam int SW_PERIOD_CYC = CLK_HZ / (SW_FREQ_KHZ * 1000);

    // Gate dead time, rounded up to cycles
    localparam int NOL_NS = 30;
    localparam int NOL_CYC = (NOL_NS + CLK_NS - 1) / CLK_NS;

    // Power-good qualification times
    localparam int PG_RISE_MS = 1;
    localparam int PG_RISE_CYC = PG_RISE_MS * (CLK_HZ / 1000);
    localparam int PG_FALL_US = 500;
    localparam int PG_FALL_CYC = PG_FALL_US * (CLK_HZ / 1_000_000);

    // Enable-level qualification time
    localparam int EN_QUAL_US = 30;
    localparam int EN_QUAL_CYC = EN_QUAL_US * (CLK_HZ / 1_000_000);

    // Soft start step time and current-limit duty cut
    localparam int SS_STEP_CYC = 200;
    localparam int CL_STEP = 8;

    // Select code decode; targets in 10 mV
    localparam logic [4:0] CODE_SHUTDOWN = 5'h1f;
    localparam logic [3:0] LOW_LAST_VALID = 4'h5;
    localparam logic [3:0] HIGH_SHUT_LOW = 4'hf;
    localparam logic [8:0] LOW_BASE_CV = 9'h0cd;
    localparam logic [8:0] LOW_STEP_CV = 9'h005;
    localparam logic [8:0] HIGH_BASE_CV = 9'h15e;
    localparam logic [8:0] HIGH_STEP_CV = 9'h00a;

    // Register bus map (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_TARGET = 4'h8;
    localparam int CTRL_INHIBIT_BIT = 0;
    localparam int CTRL_LIMIT_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;

    // Converter sequencing states
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_SOFT = 2'b01,
        ST_RUN = 2'b10
    } conv_state_e;

    // Enable threshold comparators, high when above
    typedef struct packed {
        logic above2v;
        logic above1v7;
        logic above1v2;
    } enable_lvl_s;

    // Output comparators against the target
    typedef struct packed {
        logic below95;
        logic above105;
        logic above115;
    } sense_cmp_s;

    // Power stage comparators
    typedef struct packed {
        logic belowLimit;
        logic hardLimit;
        logic pwmTrip;
    } stage_cmp_s;

endpackage

// ---- regulator_supervisor_logic_asserts.sv ----
/*
 * Assertions on the supervisor's pins.
 * Assumes binding to the top module; sees only its ports.
 */
`timescale 1ns/10ps
module regulator_supervisor_logic_asserts #(
    parameter int PG_RISE_CYC = 40,
    parameter int EN_QUAL_CYC = 10
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [4:0] voltageSelectCode,
    input wire regulator_supervisor_pkg::enable_lvl_s enableLevelInput,
    input wire regulator_supervisor_pkg::sense_cmp_s senseCmp,
    input wire regulator_supervisor_pkg::stage_cmp_s stageCmp,
    input wire logic highSideGate,
    input wire logic lowSideGate,
    input wire logic powerGoodFlag,
    input wire logic overVoltFlag_n,
    input wire logic overTempFlag_n,
    input wire logic [8:0] targetCentivolts
);
    // Qualification time plus pipeline margin
    localparam int QL = EN_QUAL_CYC + 5;
    // Cycles each enable level has been undercut
    logic [17:0] lo12Cnt, lo17Cnt, lo2Cnt;
    // In-window dwell
    logic [17:0] winCnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Undercut counters
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lo12Cnt <= '0;
            lo17Cnt <= '0;
            lo2Cnt <= '0;
        end else begin
            lo12Cnt <= enableLevelInput.above1v2 ? '0 : lo12Cnt + 18'h00001;
            lo17Cnt <= enableLevelInput.above1v7 ? '0 : lo17Cnt + 18'h00001;
            lo2Cnt <= enableLevelInput.above2v ? '0 : lo2Cnt + 18'h00001;
        end
    end

    // In-window counter, saturating
    always_ff @(posedge clk_sys) begin
        if (!rst_n || senseCmp.below95 || senseCmp.above105) begin
            winCnt <= '0;
        end else if (winCnt != 18'h3ffff) begin
            winCnt <= winCnt + 18'h00001;
        end
    end

    property p_noOverlap;
        highSideGate |-> !lowSideGate;
    endproperty
    a_noOverlap: assert property (p_noOverlap) else $error("gates overlap");
    property p_disCode;
        (!voltageSelectCode[4] && voltageSelectCode[3:0] > 4'h5)[*7]
            |-> targetCentivolts == 9'h000;
    endproperty
    a_disCode: assert property (p_disCode) else $error("disabled code decoded");
    property p_shutCode;
        (voltageSelectCode == 5'h1f)[*7] |-> targetCentivolts == 9'h000
            && !powerGoodFlag && !highSideGate && !lowSideGate;
    endproperty
    a_shutCode: assert property (p_shutCode) else $error("shutdown code runs");
    property p_enOff;
        int'(lo12Cnt) > QL |-> !powerGoodFlag && overVoltFlag_n && !highSideGate
            && !lowSideGate;
    endproperty
    a_enOff: assert property (p_enOff) else $error("enable low not off");
    property p_otLow;
        int'(lo2Cnt) > QL |-> !overTempFlag_n;
    endproperty
    a_otLow: assert property (p_otLow) else $error("temp flag high");
    property p_drvOff;
        int'(lo17Cnt) > QL |-> !highSideGate && !lowSideGate;
    endproperty
    a_drvOff: assert property (p_drvOff) else $error("drivers not off");
    property p_otQual;
        $fell(enableLevelInput.above2v) && overTempFlag_n |=> overTempFlag_n[*8];
    endproperty
    a_otQual: assert property (p_otQual) else $error("temp flag early");
    property p_ovSet;
        (senseCmp.above115 && enableLevelInput.above1v2 && voltageSelectCode != 5'h1f)[*7]
            |-> !overVoltFlag_n && !highSideGate && !lowSideGate;
    endproperty
    a_ovSet: assert property (p_ovSet) else $error("overvoltage missed");
    property p_ovLatch;
        (!overVoltFlag_n && enableLevelInput.above1v2)[*3] |=> !overVoltFlag_n;
    endproperty
    a_ovLatch: assert property (p_ovLatch) else $error("overvoltage lost");
    property p_pgRise;
        $rose(powerGoodFlag) |-> int'(winCnt) >= PG_RISE_CYC;
    endproperty
    a_pgRise: assert property (p_pgRise) else $error("power good early");
    property p_hardCut;
        stageCmp.hardLimit[*7] |-> !highSideGate;
    endproperty
    a_hardCut: assert property (p_hardCut) else $error("hard limit ignored");
    c_pgUp: cover property ($rose(powerGoodFlag));
    c_ovHit: cover property ($fell(overVoltFlag_n));
    c_lowSide: cover property ($rose(lowSideGate));
endmodule

bind regulator_supervisor_logic regulator_supervisor_logic_asserts #(
    .PG_RISE_CYC(PG_RISE_CYC), .EN_QUAL_CYC(EN_QUAL_CYC)
) chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .voltageSelectCode(voltageSelectCode),
    .enableLevelInput(enableLevelInput), .senseCmp(senseCmp), .stageCmp(stageCmp),
    .highSideGate(highSideGate), .lowSideGate(lowSideGate), .powerGoodFlag(powerGoodFlag),
    .overVoltFlag_n(overVoltFlag_n), .overTempFlag_n(overTempFlag_n),
    .targetCentivolts(targetCentivolts)
);

// ---- power_stage_model.sv ----
/*
 * Power stage and output sense comparators.
 * Assumes the bench picks zone and overload.
 */
`timescale 1ns/10ps
module power_stage_model #(
    parameter int TRIP_CYC = 20
) (
    input wire logic clk_sys,
    input wire logic highSideGate,
    input wire logic overload,
    input wire logic hardHit,
    input wire logic [1:0] senseZone,
    output regulator_supervisor_pkg::stage_cmp_s stageCmp,
    output regulator_supervisor_pkg::sense_cmp_s senseCmp
);
    // Cycles the high side has been on; drives the PWM trip
    logic [7:0] onCnt = 8'h00;

    // On-time ramp, cleared when the high side turns off
    always_ff @(posedge clk_sys) begin
        onCnt <= highSideGate ? onCnt + 8'h01 : 8'h00;
    end

    // Comparator results seen by the controller
    always_comb begin
        stageCmp.belowLimit = overload && highSideGate;
        stageCmp.hardLimit = hardHit;
        stageCmp.pwmTrip = onCnt >= 8'(TRIP_CYC);
        senseCmp.below95 = senseZone == 2'h0;
        senseCmp.above105 = senseZone >= 2'h2;
        senseCmp.above115 = senseZone == 2'h3;
    end
endmodule

// ---- regulator_supervisor_logic_test.sv ----
/*
 * Self-checking bench for the supervisor.
 * Assumes the stage model and bound checker.
 */
`timescale 1ns/10ps
module regulator_supervisor_logic_test;
    localparam int PGR = 40;
    localparam int PGF = 20;
    localparam int ENQ = 10;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wbCycI = 1'b0, wbStbI = 1'b0, wbWeI = 1'b0;
    logic [3:0] wbAdrI = 4'h0;
    logic [31:0] wbDatI = 32'h0;
    logic [3:0] wbSelI = 4'h0;
    logic [31:0] wbDatO, rv;
    logic wbAckO, hs, ls, pg, ovN, otN, overload = 1'b0, hardHit = 1'b0;
    logic [4:0] code = 5'h10;
    logic [8:0] tgt;
    logic [1:0] zone = 2'h0;
    regulator_supervisor_pkg::enable_lvl_s lvl = 3'b111;
    regulator_supervisor_pkg::sense_cmp_s sense;
    regulator_supervisor_pkg::stage_cmp_s stage;
    int fails = 0;
    int nTests = 0;
    logic [31:0] busQ[$];
    logic [13:0] pinQ[$], maskQ[$];
    event snap;

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    regulator_supervisor_logic #(.PG_RISE_CYC(PGR), .PG_FALL_CYC(PGF), .EN_QUAL_CYC(ENQ),
        .SW_PERIOD_CYC(40)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .wbCycI(wbCycI),
        .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbDatI(wbDatI), .wbSelI(wbSelI),
        .wbDatO(wbDatO), .wbAckO(wbAckO), .voltageSelectCode(code), .enableLevelInput(lvl),
        .senseCmp(sense), .stageCmp(stage), .highSideGate(hs), .lowSideGate(ls),
        .powerGoodFlag(pg), .overVoltFlag_n(ovN), .overTempFlag_n(otN),
        .targetCentivolts(tgt));
    power_stage_model stg (.clk_sys(clk_sys), .highSideGate(hs), .overload(overload),
        .hardHit(hardHit), .senseZone(zone), .stageCmp(stage), .senseCmp(sense));

    task automatic tallyAndFinish;
        if (fails == 0 && nTests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmpBus(input logic [31:0] e, g);
        nTests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] wbDatO exp %h got %h", e, g);
        end
    endtask
    task automatic cmpPins(input logic [13:0] m, e, g);
        nTests++;
        if ((g & m) !== (e & m)) begin
            fails++;
            $display("[FAIL] pins exp %h got %h", e & m, g & m);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // One classic bus cycle; reads note their expected data first
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [31:0] e);
        int n;
        n = 0;
        if (!we) busQ.push_back(e);
        wbCycI <= 1'b1;
        wbStbI <= 1'b1;
        wbWeI <= we;
        wbAdrI <= a;
        wbDatI <= d;
        wbSelI <= s;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAckO !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        wbCycI <= 1'b0;
        wbStbI <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Notes expected pins under a mask and asks the monitor to look
    task automatic chk(input logic [13:0] m, input logic [13:0] e);
        #1;
        maskQ.push_back(m);
        pinQ.push_back(e);
        ->snap;
        @(posedge clk_sys);
    endtask
    function automatic logic [8:0] tgtOf(input logic [4:0] c);
        if (c == 5'h1f || (!c[4] && c[3:0] > 4'h5)) return 9'h000;
        if (!c[4]) return 9'h0cd - 9'h005 * {4'h0, c};
        return 9'h15e - 9'h00a * {5'h00, c[3:0]};
    endfunction

    // Monitors: read data on ack, pins on request
    always @(posedge clk_sys) begin
        if (wbAckO === 1'b1 && wbWeI === 1'b0) cmpBus(busQ.pop_front(), wbDatO);
    end
    always @(snap) cmpPins(maskQ.pop_front(), pinQ.pop_front(), {hs, ls, pg, ovN, otN, tgt});

    // Watchdog
    initial begin
        step(30000);
        fails++;
        tallyAndFinish();
    end

    initial begin
        void'($urandom(32'h1b1b));
        step(20);
        rst_n <= 1'b1;
        step(1);
        rv = $urandom;
        wb(1'b0, 4'h0, 32'h0, 4'hf, 32'h2);
        wb(1'b1, 4'hc, rv, 4'hf, 32'h0);
        wb(1'b0, 4'hc, 32'h0, 4'hf, 32'h0);
        wb(1'b1, 4'h0, rv, 4'h1, 32'h0);
        wb(1'b1, 4'h0, ~rv, 4'he, 32'h0);
        wb(1'b0, 4'h0, 32'h0, 4'hf, {30'h0, rv[1:0]});
        wb(1'b1, 4'h0, 32'h2, 4'h1, 32'h0);
        wb(1'b1, 4'h8, rv, 4'hf, 32'h0);
        wb(1'b0, 4'h8, 32'h0, 4'hf, 32'h15e);
        for (int c = 0; c < 32; c++) begin
            code <= 5'(c);
            step(6);
            chk(14'h01ff, {5'h00, tgtOf(5'(c))});
        end
        code <= 5'h10;
        for (int i = 0; i < 2; i++) begin
            zone <= 2'h1;
            step(PGR - 3);
            chk(14'h0800, 14'h0);
            step(12);
            chk(14'h0800, 14'h0800);
            zone <= i ? 2'h0 : 2'h2;
            step(PGF - 3);
            chk(14'h0800, 14'h0800);
            step(12);
            chk(14'h0800, 14'h0);
        end
        zone <= 2'h1;
        overload <= 1'b1;
        step(1200);
        overload <= 1'b0;
        hardHit <= 1'b1;
        step(8);
        chk(14'h2000, 14'h0);
        hardHit <= 1'b0;
        step(regulator_supervisor_pkg::SS_STEP_CYC / 2);
        chk(14'h3000, 14'h0);
        zone <= 2'h3;
        step(PGF + 5);
        chk(14'h3c00, 14'h0);
        zone <= 2'h1;
        step(20);
        chk(14'h3400, 14'h0);
        lvl <= 3'b000;
        step(ENQ + 12);
        chk(14'h3e00, 14'h0400);
        lvl <= 3'b111;
        step(12);
        chk(14'h0600, 14'h0600);
        lvl <= 3'b011;
        step(ENQ - 3);
        chk(14'h0200, 14'h0200);
        step(12);
        chk(14'h0200, 14'h0);
        lvl <= 3'b001;
        step(ENQ + 12);
        chk(14'h3200, 14'h0);
        lvl <= 3'b111;
        step(5);
        tallyAndFinish();
    end
endmodule
